// >>> hw/tcnv_defines.svh
// Constants for the thermostat conversion control: command codes, status
// bit positions, nonvolatile word addresses and timing.
// Assumes a 100 MHz core clock.
`ifndef TCNV_DEFINES_SVH
`define TCNV_DEFINES_SVH

// Function command codes
`define TCNV_CMD_READ_TEMP   8'haa
`define TCNV_CMD_START_CONV  8'hee
`define TCNV_CMD_STOP_CONV   8'h22
`define TCNV_CMD_WRITE_UPPER 8'h01
`define TCNV_CMD_WRITE_LOWER 8'h02
`define TCNV_CMD_READ_UPPER  8'ha1
`define TCNV_CMD_READ_LOWER  8'ha2
`define TCNV_CMD_WRITE_STAT  8'h0c
`define TCNV_CMD_READ_STAT   8'hac
`define TCNV_CMD_READ_CNT    8'ha0
`define TCNV_CMD_LOAD_CNT    8'h41

// Status and configuration bit positions
`define TCNV_ST_DONE   7
`define TCNV_ST_ONE    6
`define TCNV_ST_BUSY   5
`define TCNV_ST_HIGH   4
`define TCNV_ST_LOW    3
`define TCNV_ST_MODE   2
`define TCNV_ST_POLARITY 1
`define TCNV_ST_SINGLE 0

// Nonvolatile word addresses
`define TCNV_NV_UPPER 2'h0
`define TCNV_NV_LOWER 2'h1
`define TCNV_NV_CFG   2'h2

// Factory contents: bus mode, zero trip points
`define TCNV_NV_RESET 8'h00

// Timing
`define TCNV_CLK_KHZ 100000
`define TCNV_CONV_MS 1000
`define TCNV_NVWR_MS 10

`endif

// >>> hw/tcnv_pkg.sv
// Types shared by the thermostat conversion control and its bench.
// Assumes tcnv_defines.svh holds the numeric constants.
package tcnv_pkg;

    typedef enum logic [1:0] {
        TCNV_ST_LOADING = 2'b01,
        TCNV_ST_READY = 2'b10
    } tcnv_state_t;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] wdata;
    } tcnv_cmd_t;

    typedef struct packed {
        logic [7:0] temp;
        logic [8:0] remain;
        logic [8:0] slope;
    } tcnv_meas_t;

endpackage : tcnv_pkg

// >>> hw/tcnv_nvmem.sv
// Nonvolatile store of three words: upper trip, lower trip, configuration.
// Assumes one write at a time; a write holds busy for the programming time.
`timescale 1ns/1ps
`include "tcnv_defines.svh"

module tcnv_nvmem #(
    parameter int unsigned WR_CYCLES = `TCNV_NVWR_MS * `TCNV_CLK_KHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Access
    input wire logic wr_en,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q,
    output logic busy_q
);
    logic [7:0] mem [0:2];
    logic [31:0] wr_cnt_q;

    // Contents survive resetn, which models a power cycle
    initial begin
        for (int i = 0; i < 3; i++) begin
            mem[i] = `TCNV_NV_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en && !busy_q && addr != 2'h3) begin
            mem[addr] <= wdata;
        end
        rdata_q <= (addr == 2'h3) ? 8'h00 : mem[addr];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            wr_cnt_q <= 32'h0;
        end else if (wr_en && !busy_q) begin
            busy_q <= 1'b1;
            wr_cnt_q <= WR_CYCLES - 32'd1;
        end else if (busy_q) begin
            wr_cnt_q <= wr_cnt_q - 32'd1;
            busy_q <= (wr_cnt_q != 32'h0);
        end
    end

endmodule : tcnv_nvmem

// >>> hw/tcnv_ctrl.sv
// Conversion and thermostat control of a digital thermometer.
// Assumes commands arrive already decoded from the serial line, one per
// pulse, on the core clock, and that the sensing front end presents its
// result on the same clock.
//
// Operation
// R01: Temperature held as 8-bit two's complement, bit 7 is sign.
// R02: One degree per LSB, e.g. 7Dh, FFh, C9h.
// R03: Temperature readable only in bus mode.
// R04: Single-conversion select: 0 continuous, 1 one-shot.
// R05: Thermostat mode converts continuously from power-up regardless of that bit.
// R06: Continuous mode: EEh starts repeated conversions until 22h.
// R07: One-shot mode: EEh runs one conversion then standby.
// R08: One-shot: done bit 7 reads 0 while converting, 1 afterwards.
// R09: Continuous mode: done bit always reads 0.
// R10: Residual 9-bit count kept and returned by A0h.
// R11: 41h copies slope accumulator into counter register.
// R12: Host reads temperature, counter, loads counter, reads counter again.
// R13: Host computes fine temperature from coarse, remainder and counts per degree.
// R14: Thermostat output active above upper trip until below lower trip.
// R15: Trip points use the temperature format.
// R16: Host writes trip points only in bus mode.
// R17: Polarity bit 1: 1 active high, 0 active low.
// R18: High flag bit 4 set above upper trip, held until written 0.
// R19: Low flag bit 3 set below lower trip, held until written 0.
// R20: Flags update in both modes.
// R21: Flags, mode, polarity, single select are nonvolatile.
// R22: Status layout: done, 1, busy, high, low, mode, polarity, single.
// R23: Nonvolatile busy reads 1 while storage writes.
// R24: Host starts no storage write while one is running.
// R25: Line bytes travel least significant bit first.
// R26: Power-up mode bit: 0 bus mode, 1 thermostat mode.
// R27: Comparisons signed, evaluated at end of each conversion.
// R28: Status writes leave done, busy and bit 6 unchanged.
`timescale 1ns/1ps
`include "tcnv_defines.svh"

module tcnv_ctrl #(
    parameter int unsigned CONV_CYCLES = `TCNV_CONV_MS * `TCNV_CLK_KHZ,
    parameter int unsigned NVWR_CYCLES = `TCNV_NVWR_MS * `TCNV_CLK_KHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Decoded command from the line
    input wire logic cmd_valid,
    input wire tcnv_pkg::tcnv_cmd_t cmd,
    output logic cmd_ready_q,
    // Read answer, low bits first on the line
    output logic rsp_valid_q,
    output logic [8:0] rsp_data_q, // R25
    // Sensing front end
    output logic conv_active_q,
    input wire tcnv_pkg::tcnv_meas_t meas,
    // Open-drain data/thermostat pin
    output logic dq_o_q,
    output logic dq_oe_q,
    // Mode shown to the line logic: 1 thermostat, 0 bus
    output logic therm_mode_q
);
    import tcnv_pkg::*;

    tcnv_state_t state_q;
    logic [1:0] ld_q;
    logic [7:0] temp_q, upper_q, lower_q;
    logic [8:0] count_q, slope_q;
    logic flag_hi_q, flag_lo_q, polarity_q, single_q, pwr_mode_q;
    logic run_q, shot_q, done_q, therm_act_q;
    logic [31:0] conv_cnt_q;
    logic [2:0] pend_q;
    logic nv_wr_en;
    logic [1:0] nv_addr;
    logic [7:0] nv_wdata, nv_rdata;
    logic nv_busy;

    function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction : sgt

    function automatic logic is_cmd(input logic v, input logic [7:0] c,
                                    input logic [7:0] code);
        is_cmd = v && (c == code);
    endfunction : is_cmd

    // Command decode; nothing is accepted in thermostat mode or while loading
    wire ready = (state_q == TCNV_ST_READY) && !therm_mode_q; // R03
    wire take = cmd_valid && ready;
    wire c_start = is_cmd(take, cmd.code, `TCNV_CMD_START_CONV);
    wire c_stop = is_cmd(take, cmd.code, `TCNV_CMD_STOP_CONV);
    wire c_wr_up = is_cmd(take, cmd.code, `TCNV_CMD_WRITE_UPPER);
    wire c_wr_lo = is_cmd(take, cmd.code, `TCNV_CMD_WRITE_LOWER);
    wire c_wr_st = is_cmd(take, cmd.code, `TCNV_CMD_WRITE_STAT);
    wire c_load = is_cmd(take, cmd.code, `TCNV_CMD_LOAD_CNT);
    wire c_rd_tmp = is_cmd(take, cmd.code, `TCNV_CMD_READ_TEMP);
    wire c_rd_up = is_cmd(take, cmd.code, `TCNV_CMD_READ_UPPER);
    wire c_rd_lo = is_cmd(take, cmd.code, `TCNV_CMD_READ_LOWER);
    wire c_rd_st = is_cmd(take, cmd.code, `TCNV_CMD_READ_STAT);
    wire c_rd_cnt = is_cmd(take, cmd.code, `TCNV_CMD_READ_CNT);
    wire c_read = c_rd_tmp | c_rd_up | c_rd_lo | c_rd_st | c_rd_cnt;

    // Conversion timing
    wire converting = run_q | shot_q;
    wire conv_end = converting && (conv_cnt_q == CONV_CYCLES - 32'd1);
    wire [31:0] conv_cnt_d = (!converting || conv_end) ? 32'h0 : conv_cnt_q + 32'd1;
    wire hi_set = conv_end && sgt(meas.temp, upper_q); // R27 R20
    wire lo_set = conv_end && sgt(lower_q, meas.temp); // R27 R20

    // Status byte
    wire done_rd = done_q & single_q; // R09
    wire [7:0] cfg_byte = {3'b000, flag_hi_q, flag_lo_q, pwr_mode_q, polarity_q, single_q};
    wire [7:0] stat_byte = {done_rd, 1'b1, nv_busy, cfg_byte[4:0]}; // R22 R23

    // Flags: a conversion setting a flag wins over a host write of 0
    wire hi_d = (c_wr_st ? cmd.wdata[`TCNV_ST_HIGH] : flag_hi_q) | hi_set; // R18
    wire lo_d = (c_wr_st ? cmd.wdata[`TCNV_ST_LOW] : flag_lo_q) | lo_set; // R19

    // Hysteresis: on above upper, off below lower
    wire therm_d = hi_set ? 1'b1 : (lo_set ? 1'b0 : therm_act_q); // R14
    wire level_d = polarity_q ? therm_d : ~therm_d; // R17

    wire [8:0] rsp_d = c_rd_tmp ? {1'b0, temp_q} :
                       c_rd_up ? {1'b0, upper_q} :
                       c_rd_lo ? {1'b0, lower_q} :
                       c_rd_st ? {1'b0, stat_byte} : count_q;

    // Storage write-back: loading uses the read port, then pending words drain
    wire loading = (state_q == TCNV_ST_LOADING);
    wire [2:0] pend_new = {(c_wr_st | (hi_d != flag_hi_q) | (lo_d != flag_lo_q)),
                           c_wr_lo, c_wr_up};
    wire [1:0] pick = pend_q[0] ? `TCNV_NV_UPPER :
                      pend_q[1] ? `TCNV_NV_LOWER : `TCNV_NV_CFG;
    assign nv_wr_en = !loading && !nv_busy && (pend_q != 3'b000); // R21
    assign nv_addr = loading ? ld_q : pick;
    assign nv_wdata = (pick == `TCNV_NV_UPPER) ? upper_q :
                      (pick == `TCNV_NV_LOWER) ? lower_q : cfg_byte;
    wire [2:0] pend_done = nv_wr_en ? (3'b001 << pick) : 3'b000;

    tcnv_nvmem #(
        .WR_CYCLES(NVWR_CYCLES)
    ) u_nvmem (
        .clk(clk),
        .resetn(resetn),
        .wr_en(nv_wr_en),
        .addr(nv_addr),
        .wdata(nv_wdata),
        .rdata_q(nv_rdata),
        .busy_q(nv_busy)
    );

    // Power-up load of the stored words, one per cycle behind the read latency
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= TCNV_ST_LOADING;
            ld_q <= 2'h0;
        end else begin
            case (state_q)
                TCNV_ST_LOADING: begin
                    ld_q <= ld_q + 2'h1;
                    if (ld_q == 2'h3) begin
                        state_q <= TCNV_ST_READY;
                    end
                end
                TCNV_ST_READY: state_q <= TCNV_ST_READY;
                default: state_q <= TCNV_ST_LOADING;
            endcase
        end
    end

    // Trip points: reset to constants, then taken from storage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upper_q <= 8'h00;
            lower_q <= 8'h00;
        end else if (loading) begin
            if (ld_q == 2'h1) begin
                upper_q <= nv_rdata;
            end
            if (ld_q == 2'h2) begin
                lower_q <= nv_rdata;
            end
        end else begin
            if (c_wr_up) begin
                upper_q <= cmd.wdata; // R15
            end
            if (c_wr_lo) begin
                lower_q <= cmd.wdata; // R15
            end
        end
    end

    // Configuration bits; done, busy and bit 6 have no storage to write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {flag_hi_q, flag_lo_q, pwr_mode_q, polarity_q, single_q} <= 5'h00;
        end else if (loading) begin
            if (ld_q == 2'h3) begin
                {flag_hi_q, flag_lo_q, pwr_mode_q, polarity_q, single_q} <= nv_rdata[4:0];
            end
        end else begin
            flag_hi_q <= hi_d;
            flag_lo_q <= lo_d;
            if (c_wr_st) begin
                {pwr_mode_q, polarity_q, single_q} <= cmd.wdata[2:0]; // R28
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_q <= 3'b000;
        end else begin
            pend_q <= (pend_q & ~pend_done) | pend_new;
        end
    end

    // Operating mode is fixed at power-up; rewriting the bit takes effect next time
    always_ff @(posedge clk) begin
        if (!resetn) begin
            therm_mode_q <= 1'b0;
        end else if (loading && ld_q == 2'h3) begin
            therm_mode_q <= nv_rdata[`TCNV_ST_MODE]; // R26
        end
    end

    // Continuous conversion control
    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_q <= 1'b0;
        end else if (loading && ld_q == 2'h3 && nv_rdata[`TCNV_ST_MODE]) begin
            run_q <= 1'b1; // R05
        end else if (c_start && !single_q) begin
            run_q <= 1'b1; // R06
        end else if (c_stop && !single_q) begin
            run_q <= 1'b0; // R06
        end
    end

    // One-shot: a start while converting is ignored
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shot_q <= 1'b0;
            done_q <= 1'b0;
        end else if (c_start && single_q && !converting) begin // R04
            shot_q <= 1'b1; // R07
            done_q <= 1'b0; // R08
        end else if (conv_end && shot_q) begin
            shot_q <= 1'b0; // R07
            done_q <= 1'b1; // R08
        end
    end

    // Gate period counter restarts at once, so conversions run back to back
    always_ff @(posedge clk) begin
        if (!resetn) begin
            conv_cnt_q <= 32'h0;
        end else begin
            conv_cnt_q <= conv_cnt_d;
        end
    end

    // Results captured when the gate period closes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            temp_q <= 8'h00;
            slope_q <= 9'h000;
            count_q <= 9'h000;
        end else if (conv_end) begin
            temp_q <= meas.temp; // R01 R02
            slope_q <= meas.slope;
            count_q <= meas.remain; // R10
        end else if (c_load) begin
            count_q <= slope_q; // R11
        end
    end

    // Read answers, one cycle after the command
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 9'h000;
            cmd_ready_q <= 1'b0;
        end else begin
            rsp_valid_q <= c_read; // R03
            if (c_read) rsp_data_q <= rsp_d; // R10
            cmd_ready_q <= (state_q == TCNV_ST_READY) && !therm_mode_q;
        end
    end

    // Thermostat state and front-end gate, one cycle behind the decision
    always_ff @(posedge clk) begin
        if (!resetn) begin
            therm_act_q <= 1'b0;
            conv_active_q <= 1'b0;
        end else begin
            therm_act_q <= therm_d; // R14
            conv_active_q <= converting;
        end
    end

    // Thermostat pin: open drain pulls low when the level is 0
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dq_oe_q <= 1'b0;
            dq_o_q <= 1'b0;
        end else begin
            dq_oe_q <= therm_mode_q && !level_d; // R17
            dq_o_q <= 1'b0;
        end
    end

endmodule : tcnv_ctrl

// >>> bench/tcnv_ctrl_monitor.sv
// Port checker for the conversion control.
// Assumes it is bound into tcnv_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`include "tcnv_defines.svh"

module tcnv_ctrl_monitor #(
    parameter int unsigned CONV_CYCLES = 20,
    parameter int unsigned NVWR_CYCLES = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command and answer
    input wire logic cmd_valid,
    input wire tcnv_pkg::tcnv_cmd_t cmd,
    input wire logic cmd_ready_q,
    input wire logic rsp_valid_q,
    input wire logic [8:0] rsp_data_q,
    // Front end and pin
    input wire logic conv_active_q,
    input wire tcnv_pkg::tcnv_meas_t meas,
    input wire logic dq_o_q,
    input wire logic dq_oe_q,
    input wire logic therm_mode_q
);
    import tcnv_pkg::*;
    logic [7:0] code_q;
    logic is_rd;
    logic is_stat;
    assign is_rd = cmd.code inside {`TCNV_CMD_READ_TEMP, `TCNV_CMD_READ_UPPER,
        `TCNV_CMD_READ_LOWER, `TCNV_CMD_READ_STAT, `TCNV_CMD_READ_CNT};
    assign is_stat = rsp_valid_q && code_q == `TCNV_CMD_READ_STAT;
    // Remembers which read an answer belongs to
    always_ff @(posedge clk) begin
        if (cmd_valid) begin
            code_q <= cmd.code;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    read_answer_a: assert property (cmd_valid && cmd_ready_q && is_rd |=> rsp_valid_q)
        else $error("read not answered");
    write_quiet_a: assert property (cmd_valid && !is_rd |=> !rsp_valid_q)
        else $error("answer to a non-read");
    answer_cause_a: assert property (rsp_valid_q |-> $past(cmd_valid))
        else $error("answer without command");
    data_hold_a: assert property (!rsp_valid_q |-> $stable(rsp_data_q))
        else $error("read data moved");
    status_layout_a: assert property (is_stat |-> !rsp_data_q[8] && rsp_data_q[6])
        else $error("status bit 6 not one");
    done_low_a: assert property (is_stat && conv_active_q |-> !rsp_data_q[7])
        else $error("done set while converting");
    byte_width_a: assert property (rsp_valid_q && code_q != `TCNV_CMD_READ_CNT
        |-> !rsp_data_q[8])
        else $error("byte read not zero extended");
    start_conv_a: assert property (cmd_valid && cmd_ready_q
        && cmd.code == `TCNV_CMD_START_CONV |-> ##2 conv_active_q)
        else $error("start did not convert");
    pin_drive_a: assert property (dq_oe_q |-> therm_mode_q && !dq_o_q)
        else $error("pin driven outside thermostat mode");
    therm_shut_a: assert property (therm_mode_q |-> !cmd_ready_q && !rsp_valid_q)
        else $error("commands open in thermostat mode");
    therm_conv_a: assert property (therm_mode_q[*3] |-> conv_active_q)
        else $error("thermostat mode not converting");
endmodule : tcnv_ctrl_monitor

bind tcnv_ctrl tcnv_ctrl_monitor #(.CONV_CYCLES(CONV_CYCLES), .NVWR_CYCLES(NVWR_CYCLES))
    u_mon (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .conv_active_q(conv_active_q), .meas(meas), .dq_o_q(dq_o_q), .dq_oe_q(dq_oe_q),
    .therm_mode_q(therm_mode_q));

// >>> bench/tcnv_host_model.sv
// Host model: issues decoded commands one at a time.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/1ps
`include "tcnv_defines.svh"

module tcnv_host_model (
    // Clock
    input wire logic clk,
    // Command and answer
    output logic cmd_valid,
    output tcnv_pkg::tcnv_cmd_t cmd,
    input wire logic cmd_ready_q,
    input wire logic rsp_valid_q,
    input wire logic [8:0] rsp_data_q,
    // A wait ran out
    output logic hang
);
    import tcnv_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        hang = 1'b0;
    end
    // Missing answer reads as 1ffh; idle command bits are scrambled
    task automatic xfer(input logic [7:0] c, input logic [7:0] w, output logic [8:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready_q !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n == 400) hang = 1'b1;
        cmd_valid = 1'b1;
        cmd = '{c, w};
        @(negedge clk);
        d = rsp_valid_q ? rsp_data_q : 9'h1ff;
        cmd_valid = 1'b0;
        cmd = ~cmd;
    endtask : xfer
    // Storage write only after storage reports idle
    task automatic wr_nv(input logic [7:0] c, input logic [7:0] w);
        logic [8:0] s;
        int n;
        n = 0;
        s = 9'h020;
        repeat (2) @(negedge clk);
        while (s[5] !== 1'b0 && n < 50) begin
            xfer(`TCNV_CMD_READ_STAT, 8'h00, s);
            n++;
        end
        if (n == 50) hang = 1'b1;
        xfer(c, w, s);
    endtask : wr_nv
endmodule : tcnv_host_model

// >>> bench/tcnv_ctrl_tb.sv
// Self-checking bench for the conversion control.
// Assumes short conversion and storage counts to keep the run brief.
`timescale 1ns/1ps
`include "tcnv_defines.svh"

module tcnv_ctrl_tb;
    import tcnv_pkg::*;
    localparam int unsigned CONV = 20;
    logic clk, resetn, cmd_valid, cmd_ready_q, rsp_valid_q, conv_active_q;
    logic dq_o_q, dq_oe_q, therm_mode_q, hang;
    tcnv_cmd_t cmd;
    tcnv_meas_t meas;
    logic [8:0] rsp_data_q;
    logic [8:0] d;
    int bad_count;
    int checked;

    tcnv_ctrl #(.CONV_CYCLES(CONV), .NVWR_CYCLES(5)) DUT (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .conv_active_q(conv_active_q),
        .meas(meas), .dq_o_q(dq_o_q), .dq_oe_q(dq_oe_q), .therm_mode_q(therm_mode_q));
    tcnv_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
        .hang(hang));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chkb(input string name, input logic exp, input logic got);
        chk(name, {8'h00, exp}, {8'h00, got});
    endtask : chkb

    task automatic end_sim;
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic rd(input logic [7:0] c);
        u_host.xfer(c, 8'h00, d);
    endtask : rd

    task automatic run(input logic [7:0] t);
        meas.temp = t;
        repeat (CONV + 4) @(negedge clk);
    endtask : run

    task automatic do_reset;
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
    endtask : do_reset

    task automatic t_status;
        rd(`TCNV_CMD_READ_STAT);
        chk("status", 9'h040, d);
        chkb("mode", 1'b0, therm_mode_q);
    endtask : t_status

    task automatic t_trip;
        u_host.wr_nv(`TCNV_CMD_WRITE_UPPER, 8'h19);
        u_host.wr_nv(`TCNV_CMD_WRITE_LOWER, 8'he7);
        rd(`TCNV_CMD_READ_STAT);
        chk("busy", 9'h020, d & 9'h020);
        rd(`TCNV_CMD_READ_UPPER);
        chk("upper", 9'h019, d);
        rd(`TCNV_CMD_READ_LOWER);
        chk("lower", 9'h0e7, d);
        repeat (20) @(negedge clk);
        rd(`TCNV_CMD_READ_STAT);
        chk("idle", 9'h000, d & 9'h020);
    endtask : t_trip

    task automatic t_cont;
        logic [8:0] rem;
        meas = '{8'hc9, 9'h0a5, 9'h110};
        u_host.xfer(`TCNV_CMD_START_CONV, 8'h00, d);
        run(8'hc9);
        rd(`TCNV_CMD_READ_TEMP);
        chk("temp", 9'h0c9, d);
        rd(`TCNV_CMD_READ_STAT);
        chk("flags", 9'h048, d & 9'h1df);
        run(8'h7d);
        rd(`TCNV_CMD_READ_TEMP);
        chk("temp", 9'h07d, d);
        rd(`TCNV_CMD_READ_STAT);
        chk("flags", 9'h058, d & 9'h1df);
        u_host.xfer(`TCNV_CMD_STOP_CONV, 8'h00, d);
        @(negedge clk);
        chkb("stopped", 1'b0, conv_active_q);
        rd(`TCNV_CMD_READ_CNT);
        chk("remain", 9'h0a5, d);
        rem = d;
        u_host.xfer(`TCNV_CMD_LOAD_CNT, 8'h00, d);
        rd(`TCNV_CMD_READ_CNT);
        chk("slope", 9'h110, d);
        chk("count span", 9'h06b, d - rem);
        u_host.wr_nv(`TCNV_CMD_WRITE_STAT, 8'h00);
        rd(`TCNV_CMD_READ_STAT);
        chk("cleared", 9'h040, d & 9'h1df);
    endtask : t_cont

    task automatic t_oneshot;
        int n;
        u_host.wr_nv(`TCNV_CMD_WRITE_STAT, 8'he1);
        rd(`TCNV_CMD_READ_STAT);
        chk("config", 9'h041, d & 9'h15f);
        u_host.xfer(`TCNV_CMD_START_CONV, 8'h00, d);
        rd(`TCNV_CMD_READ_STAT);
        chk("done", 9'h000, d & 9'h080);
        u_host.xfer(`TCNV_CMD_STOP_CONV, 8'h00, d);
        chkb("no stop", 1'b1, conv_active_q);
        n = 0;
        while (conv_active_q !== 1'b0 && n < CONV + 10) begin
            @(negedge clk);
            n++;
        end
        if (n == CONV + 10) u_host.hang = 1'b1;
        rd(`TCNV_CMD_READ_STAT);
        chk("done", 9'h080, d & 9'h080);
        repeat (CONV + 5) @(negedge clk);
        chkb("standby", 1'b0, conv_active_q);
    endtask : t_oneshot

    task automatic t_therm;
        u_host.wr_nv(`TCNV_CMD_WRITE_STAT, 8'h07);
        repeat (20) @(negedge clk);
        meas.temp = 8'h00;
        do_reset;
        run(8'h00);
        chkb("mode", 1'b1, therm_mode_q);
        chkb("closed", 1'b0, cmd_ready_q);
        chkb("converting", 1'b1, conv_active_q);
        chkb("pin", 1'b1, dq_oe_q);
        run(8'h7d);
        chkb("pin", 1'b0, dq_oe_q);
        run(8'h00);
        chkb("pin", 1'b0, dq_oe_q);
        run(8'hc9);
        chkb("pin", 1'b1, dq_oe_q);
    endtask : t_therm

    initial begin
        resetn = 1'b0;
        meas = '0;
        bad_count = 0;
        checked = 0;
        do_reset;
        t_status;
        t_trip;
        t_cont;
        t_oneshot;
        t_therm;
        end_sim;
    end

    always @(posedge hang) begin
        bad_count++;
        end_sim;
    end
endmodule : tcnv_ctrl_tb
